// ==== verilog/io_expander_pkg.sv ====
// Constants, types and register map of the sixteen-bit I2C I/O expander.
package io_expander_pkg;

	// Register pointers carried by the command byte.
	localparam logic [2:0] PTR_IN0 = 3'h0;
	localparam logic [2:0] PTR_IN1 = 3'h1;
	localparam logic [2:0] PTR_OUT0 = 3'h2;
	localparam logic [2:0] PTR_OUT1 = 3'h3;
	localparam logic [2:0] PTR_INV0 = 3'h4;
	localparam logic [2:0] PTR_INV1 = 3'h5;
	localparam logic [2:0] PTR_DIR0 = 3'h6;
	localparam logic [2:0] PTR_DIR1 = 3'h7;

	// Values after reset; a direction bit of one means input.
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam logic [7:0] DRIVE_RESET = 8'hFF;
	localparam logic [7:0] INV_RESET = 8'h00;

	// Upper six address bits; the address pin supplies the lowest bit.
	localparam logic [5:0] ADDR_BASE = 6'h10;

	// Cycles after reset during which the latched inputs track the pins.
	localparam logic [1:0] PRIME_DONE = 2'h3;

	// Bits in one byte on the bus.
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// Time from reset release to the first START that the host may send.
	localparam int RESET_TO_START_NS = 600;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RESET_TO_START_CYCLES = (RESET_TO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WDATA,
		ST_WACK,
		ST_RDATA,
		ST_RACK
	} bus_state_type;

endpackage

// ==== verilog/io_expander.sv ====
// Sixteen-bit I/O expander with an I2C target port, sampled on the system clock.
`timescale 1ns/1ps

module io_expander (
	// Clock, reset and enable
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// I2C bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_addr,
	// Change alert, open drain
	output logic o_int_out,
	output logic o_int_oe,
	// Port pins
	input wire logic [7:0] i_port0_pins,
	output logic [7:0] o_port0_pins,
	output logic [7:0] o_port0_pins_oe,
	input wire logic [7:0] i_port1_pins,
	output logic [7:0] o_port1_pins,
	output logic [7:0] o_port1_pins_oe
);

	typedef struct packed {
		logic [18:0] sync_m;
		logic [18:0] sync_s;
		logic prev_scl;
		logic prev_sda;
		io_expander_pkg::bus_state_type st;
		logic [7:0] sh;
		logic [3:0] bits;
		logic rw;
		logic nack;
		logic [2:0] ptr;
		logic [1:0][7:0] dir;
		logic [1:0][7:0] drive;
		logic [1:0][7:0] inv;
		logic [1:0][7:0] pin_oe;
		logic [1:0][7:0] latch;
		logic [1:0] prime;
		logic sda_oe;
		logic int_oe;
	} core_type;

	localparam core_type CORE_RESET = '{
		sync_m: 19'h00000,
		sync_s: 19'h00000,
		prev_scl: 1'b0,
		prev_sda: 1'b0,
		st: io_expander_pkg::ST_IDLE,
		sh: 8'h00,
		bits: 4'h0,
		rw: 1'b0,
		nack: 1'b0,
		ptr: 3'h0,
		dir: {io_expander_pkg::DIR_RESET, io_expander_pkg::DIR_RESET},
		drive: {io_expander_pkg::DRIVE_RESET, io_expander_pkg::DRIVE_RESET},
		inv: {io_expander_pkg::INV_RESET, io_expander_pkg::INV_RESET},
		pin_oe: ~{io_expander_pkg::DIR_RESET, io_expander_pkg::DIR_RESET},
		latch: 16'h0000,
		prime: 2'h0,
		sda_oe: 1'b0,
		int_oe: 1'b0
	};

	core_type s;
	core_type next_s;
	logic [15:0] pin_now;
	logic scl;
	logic sda;
	logic addr_pin;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rd;
	logic [2:0] ptr_next;
	logic load;
	logic mismatch;

	////////////////////////////////////////////////////////////////////////////////
	// Sampled pins and bus events.

	assign pin_now = s.sync_s[15:0];
	assign sda = s.sync_s[16];
	assign scl = s.sync_s[17];
	assign addr_pin = s.sync_s[18];
	assign scl_rise = scl & ~s.prev_scl;
	assign scl_fall = ~scl & s.prev_scl;
	assign start_cond = scl & s.prev_scl & s.prev_sda & ~sda;
	assign stop_cond = scl & s.prev_scl & ~s.prev_sda & sda;

	// Auto-increment stays inside one register pair, so a burst alternates ports.
	assign ptr_next = {s.ptr[2:1], ~s.ptr[0]};

	// Only pins set as inputs can raise the alert.
	assign mismatch = (s.prime == io_expander_pkg::PRIME_DONE) &&
		(|((pin_now ^ s.latch) & s.dir));

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		next_s = s;
		load = 1'b0;
		case (s.ptr)
			io_expander_pkg::PTR_IN0: rd = pin_now[7:0] ^ s.inv[0];
			io_expander_pkg::PTR_IN1: rd = pin_now[15:8] ^ s.inv[1];
			io_expander_pkg::PTR_OUT0: rd = s.drive[0];
			io_expander_pkg::PTR_OUT1: rd = s.drive[1];
			io_expander_pkg::PTR_INV0: rd = s.inv[0];
			io_expander_pkg::PTR_INV1: rd = s.inv[1];
			io_expander_pkg::PTR_DIR0: rd = s.dir[0];
			default: rd = s.dir[1];
		endcase
		next_s.sync_m = {i_addr, i_scl, i_sda, i_port1_pins, i_port0_pins};
		next_s.sync_s = s.sync_m;
		next_s.prev_scl = scl;
		next_s.prev_sda = sda;
		// The synchronisers need two cycles to fill before the latch can be trusted.
		if (s.prime != io_expander_pkg::PRIME_DONE) begin
			next_s.prime = s.prime + 2'h1;
			next_s.latch = pin_now;
		end
		case (s.st)
			io_expander_pkg::ST_ADDR: begin
				if (scl_rise) begin
					next_s.sh = {s.sh[6:0], sda};
					next_s.bits = s.bits + 4'h1;
				end else if (scl_fall && s.bits == io_expander_pkg::BYTE_BITS) begin
					if (s.sh[7:1] == {io_expander_pkg::ADDR_BASE, addr_pin}) begin
						next_s.st = io_expander_pkg::ST_ADDR_ACK;
						next_s.sda_oe = 1'b1;
						next_s.rw = s.sh[0];
					end else begin
						// Another device is addressed: ignore the rest of the frame.
						next_s.st = io_expander_pkg::ST_IDLE;
					end
				end
			end
			io_expander_pkg::ST_ADDR_ACK: begin
				if (scl_fall) begin
					if (s.rw) begin
						load = 1'b1;
					end else begin
						next_s.st = io_expander_pkg::ST_CMD;
						next_s.sda_oe = 1'b0;
						next_s.bits = 4'h0;
					end
				end
			end
			io_expander_pkg::ST_CMD: begin
				if (scl_rise) begin
					next_s.sh = {s.sh[6:0], sda};
					next_s.bits = s.bits + 4'h1;
				end else if (scl_fall && s.bits == io_expander_pkg::BYTE_BITS) begin
					next_s.ptr = s.sh[2:0];
					next_s.st = io_expander_pkg::ST_CMD_ACK;
					next_s.sda_oe = 1'b1;
				end
			end
			io_expander_pkg::ST_CMD_ACK, io_expander_pkg::ST_WACK: begin
				if (scl_fall) begin
					next_s.st = io_expander_pkg::ST_WDATA;
					next_s.sda_oe = 1'b0;
					next_s.bits = 4'h0;
				end
			end
			io_expander_pkg::ST_WDATA: begin
				if (scl_rise) begin
					next_s.sh = {s.sh[6:0], sda};
					next_s.bits = s.bits + 4'h1;
				end else if (scl_fall && s.bits == io_expander_pkg::BYTE_BITS) begin
					// Writes to the read-only input registers are acknowledged and dropped.
					case (s.ptr)
						io_expander_pkg::PTR_OUT0: next_s.drive[0] = s.sh;
						io_expander_pkg::PTR_OUT1: next_s.drive[1] = s.sh;
						io_expander_pkg::PTR_INV0: next_s.inv[0] = s.sh;
						io_expander_pkg::PTR_INV1: next_s.inv[1] = s.sh;
						io_expander_pkg::PTR_DIR0: next_s.dir[0] = s.sh;
						io_expander_pkg::PTR_DIR1: next_s.dir[1] = s.sh;
						default: next_s.sh = s.sh;
					endcase
					next_s.ptr = ptr_next;
					next_s.st = io_expander_pkg::ST_WACK;
					next_s.sda_oe = 1'b1;
				end
			end
			io_expander_pkg::ST_RDATA: begin
				if (scl_rise) begin
					next_s.bits = s.bits + 4'h1;
				end else if (scl_fall) begin
					if (s.bits == io_expander_pkg::BYTE_BITS) begin
						next_s.st = io_expander_pkg::ST_RACK;
						next_s.sda_oe = 1'b0;
					end else begin
						next_s.sh = {s.sh[6:0], 1'b1};
						next_s.sda_oe = ~s.sh[6];
					end
				end
			end
			io_expander_pkg::ST_RACK: begin
				if (scl_rise) begin
					// Changes between byte load and this edge are lost, by design.
					if (s.ptr[2:1] == 2'h0) begin
						next_s.latch[s.ptr[0]] = s.ptr[0] ? pin_now[15:8] : pin_now[7:0];
					end
					next_s.nack = sda;
					next_s.ptr = ptr_next;
				end else if (scl_fall) begin
					if (s.nack) begin
						next_s.st = io_expander_pkg::ST_IDLE;
					end else begin
						load = 1'b1;
					end
				end
			end
			default: begin
				next_s.sda_oe = 1'b0;
			end
		endcase
		if (load) begin
			next_s.sh = rd;
			next_s.sda_oe = ~rd[7];
			next_s.bits = 4'h0;
			next_s.st = io_expander_pkg::ST_RDATA;
			if (s.ptr[2:1] == 2'h0) begin
				next_s.latch[s.ptr[0]] = s.ptr[0] ? pin_now[15:8] : pin_now[7:0];
			end
		end
		if (start_cond) begin
			next_s.st = io_expander_pkg::ST_ADDR;
			next_s.bits = 4'h0;
			next_s.sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_s.st = io_expander_pkg::ST_IDLE;
			next_s.sda_oe = 1'b0;
		end
		next_s.int_oe = mismatch;
		// The pin enables are kept in their own flops so the pads see no inverter.
		next_s.pin_oe = ~next_s.dir;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register and outputs.

	// One reset input serves both the reset pin and power-on reset.
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			s <= CORE_RESET;
		end else if (i_ce) begin
			s <= next_s;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = s.sda_oe;
	assign o_int_out = 1'b0;
	assign o_int_oe = s.int_oe;
	assign o_port0_pins = s.drive[0];
	assign o_port1_pins = s.drive[1];
	assign o_port0_pins_oe = s.pin_oe[0];
	assign o_port1_pins_oe = s.pin_oe[1];

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);

	reset_defaults_a: assert property ($past(!i_nrst) |->
		(s.st == io_expander_pkg::ST_IDLE && !o_sda_oe && !o_int_oe))
		else $error("State not at default after reset.");
	reset_inputs_a: assert property ($past(!i_nrst) |->
		(o_port0_pins_oe == 8'h00 && o_port1_pins_oe == 8'h00))
		else $error("Pins not inputs after reset.");
	alert_raise_a: assert property (i_ce && s.prime == io_expander_pkg::PRIME_DONE &&
		((pin_now ^ s.latch) & s.dir) != 16'h0000 |=> o_int_oe)
		else $error("Alert missing on input mismatch.");
	alert_quiet_a: assert property (i_ce && ((pin_now ^ s.latch) & s.dir) == 16'h0000 |=>
		!o_int_oe)
		else $error("Alert without input mismatch.");
	addr_ack_a: assert property (i_ce && s.st == io_expander_pkg::ST_ADDR && scl_fall &&
		s.bits == io_expander_pkg::BYTE_BITS && !start_cond && !stop_cond &&
		s.sh[7:1] == {io_expander_pkg::ADDR_BASE, addr_pin} |=> o_sda_oe)
		else $error("Own address not acknowledged.");
	addr_other_a: assert property (i_ce && s.st == io_expander_pkg::ST_ADDR && scl_fall &&
		s.bits == io_expander_pkg::BYTE_BITS && s.sh[7:1] != {io_expander_pkg::ADDR_BASE, addr_pin}
		|=> !o_sda_oe)
		else $error("Foreign address acknowledged.");
	drive_write_a: assert property (i_ce && s.st == io_expander_pkg::ST_WDATA && scl_fall &&
		s.bits == io_expander_pkg::BYTE_BITS && s.ptr == io_expander_pkg::PTR_OUT0 &&
		!start_cond && !stop_cond |=> o_port0_pins == $past(s.sh))
		else $error("Output write not driven.");
	invert_load_a: assert property (i_ce && load && !start_cond && !stop_cond &&
		s.ptr == io_expander_pkg::PTR_IN0 |=> s.sh == $past(pin_now[7:0] ^ s.inv[0]))
		else $error("Input byte not inverted.");
	read_clear_a: assert property (i_ce && s.st == io_expander_pkg::ST_RACK && scl_rise &&
		s.ptr == io_expander_pkg::PTR_IN1 && !start_cond && !stop_cond
		|=> s.latch[1] == $past(pin_now[15:8]))
		else $error("Read did not relatch the port.");
	stop_idle_a: assert property (i_ce && stop_cond |=>
		(s.st == io_expander_pkg::ST_IDLE && !o_sda_oe)[*2])
		else $error("Stop did not release the bus.");

	read_seen_c: cover property (s.st == io_expander_pkg::ST_RACK && scl_fall && !s.nack);
	write_seen_c: cover property (s.st == io_expander_pkg::ST_WACK ##1 o_port1_pins_oe != 8'h00);
	alert_seen_c: cover property ($rose(o_int_oe) ##[1:1000] $fell(o_int_oe));
	nack_seen_c: cover property (s.st == io_expander_pkg::ST_RACK && s.nack);

endmodule

// ==== verification/i2c_host_model.sv ====
// Behavioural I2C host that drives the bus of the expander bench.
`timescale 1ns/1ps

module i2c_host_model (
	// Clock
	input wire logic i_mclk,
	// Bus wires
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic q(input int n);
		repeat (n) @(posedge i_mclk);
	endtask

	// One bit per 20 clocks; data only moves while the clock is low.
	task automatic bit_io(input logic b, output logic r);
		o_sda_low <= !b;
		q(5);
		o_scl <= 1'b1;
		q(5);
		r = i_sda;
		q(5);
		o_scl <= 1'b0;
		q(5);
	endtask

	task automatic start_cond();
		o_sda_low <= 1'b0;
		q(5);
		o_scl <= 1'b1;
		q(5);
		o_sda_low <= 1'b1;
		q(5);
		o_scl <= 1'b0;
		q(5);
	endtask

	task automatic stop_cond();
		o_sda_low <= 1'b1;
		q(5);
		o_scl <= 1'b1;
		q(5);
		o_sda_low <= 1'b0;
		q(5);
	endtask

	// The ninth bit is released for a write and driven low to ask for more on a read.
	task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
		output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], b);
			r[i] = b;
		end
		bit_io(ack_in, ack);
	endtask

endmodule

// ==== verification/io_expander_tb_top.sv ====
// Self-checking bench for the I2C I/O expander with a behavioural host.
`timescale 1ns/1ps

module io_expander_tb_top;
	logic i_mclk, i_nrst, i_addr, scl, sda_low, sda_oe, int_oe, ack;
	logic ce, sda_out, int_out;
	logic [7:0] ext0, ext1, in0, in1, out0, out1, oe0, oe1, d0, d1;
	logic [7:0] regs [8];
	int n_fail = 0;
	int num_checks = 0;
	wire sda = !(sda_oe | sda_low);
	assign in0 = (oe0 & out0) | (~oe0 & ext0);
	assign in1 = (oe1 & out1) | (~oe1 & ext1);

	io_expander i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce), .i_scl(scl),
		.i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr(i_addr),
		.o_int_out(int_out),
		.o_int_oe(int_oe), .i_port0_pins(in0), .o_port0_pins(out0), .o_port0_pins_oe(oe0),
		.i_port1_pins(in1), .o_port1_pins(out1), .o_port1_pins_oe(oe1));
	i2c_host_model host (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (n_fail == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	function automatic logic [7:0] exp_reg(input logic [2:0] p);
		logic [7:0] pin;
		pin = p[0] ? (~regs[7] & regs[3]) | (regs[7] & ext1) : (~regs[6] & regs[2]) | (regs[6] & ext0);
		return p < 3'h2 ? pin ^ regs[{2'h2, p[0]}] : regs[p];
	endfunction

	task automatic xfer(input logic [2:0] p, input int nw, input logic [15:0] wd, input logic rdn);
		logic [7:0] r;
		host.start_cond();
		host.byte_io({io_expander_pkg::ADDR_BASE, i_addr, 1'b0}, 1'b1, r, ack);
		chk("addr_ack", ack, 1'b0);
		host.byte_io({5'h00, p}, 1'b1, r, ack);
		chk("cmd_ack", ack, 1'b0);
		for (int k = 0; k < nw; k++) begin
			host.byte_io(wd[15 - 8 * k -: 8], 1'b1, r, ack);
			chk("data_ack", ack, 1'b0);
		end
		if (rdn) begin
			host.start_cond();
			host.byte_io({io_expander_pkg::ADDR_BASE, i_addr, 1'b1}, 1'b1, r, ack);
			host.byte_io(8'hFF, 1'b0, d0, ack);
			host.byte_io(8'hFF, 1'b1, d1, ack);
		end
		host.stop_cond();
	endtask

	task automatic chk_pair(input logic [2:0] p);
		xfer(p, 0, 16'h0000, 1'b1);
		chk("read", {d0, d1}, {exp_reg(p), exp_reg(p ^ 3'h1)});
	endtask

	task automatic wait_int(input logic lvl);
		int t;
		t = 0;
		while (int_oe !== lvl && t < 100) begin
			@(posedge i_mclk);
			t++;
		end
		chk("alert", int_oe, lvl);
		if (int_oe !== lvl) complete_run();
	endtask

	task automatic do_reset();
		i_nrst <= 1'b0;
		host.q(10);
		i_nrst <= 1'b1;
		regs = '{8'h00, 8'h00, io_expander_pkg::DRIVE_RESET, io_expander_pkg::DRIVE_RESET,
			io_expander_pkg::INV_RESET, io_expander_pkg::INV_RESET,
			io_expander_pkg::DIR_RESET, io_expander_pkg::DIR_RESET};
		// The host must stay off the bus for 600 ns after release.
		host.q(io_expander_pkg::RESET_TO_START_CYCLES + 1);
		chk("pin_oe", {oe0, oe1}, ~{io_expander_pkg::DIR_RESET, io_expander_pkg::DIR_RESET});
		chk("pin_out", {out0, out1}, {io_expander_pkg::DRIVE_RESET, io_expander_pkg::DRIVE_RESET});
		chk("od_low", {sda_out, int_out}, 2'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] v;
		logic [7:0] r;
		i_nrst = 1'b0;
		i_addr = 1'b0;
		ce = 1'b1;
		ext0 = 8'hFF;
		ext1 = 8'hFF;
		v = 16'($urandom(10827));
		// The second pass resets in mid-run over written registers.
		for (int a = 0; a < 2; a++) begin
			i_addr <= a[0];
			do_reset();
			for (int p = 0; p < 8; p += 2) chk_pair(3'(p));
			host.start_cond();
			host.byte_io({io_expander_pkg::ADDR_BASE, !i_addr, 1'b0}, 1'b1, r, ack);
			chk("foreign_ack", ack, 1'b1);
			host.stop_cond();
			for (int p = 2; p < 8; p += 2) begin
				v = 16'($urandom);
				xfer(3'(p), 2, v, 1'b0);
				regs[p] = v[15:8];
				regs[p + 1] = v[7:0];
			end
			ext0 <= 8'($urandom);
			ext1 <= 8'($urandom);
			xfer(3'h0, 1, 16'h5A00, 1'b0);
			chk("pin_out", {out0, out1}, {regs[2], regs[3]});
			chk("pin_oe", {oe0, oe1}, ~{regs[6], regs[7]});
			for (int p = 0; p < 8; p += 2) chk_pair(3'(p));
		end
		xfer(3'h6, 2, 16'hFFFF, 1'b0);
		regs[6] = 8'hFF;
		regs[7] = 8'hFF;
		chk_pair(3'h0);
		wait_int(1'b0);
		ext0 <= ext0 ^ 8'h10;
		wait_int(1'b1);
		ext0 <= ext0 ^ 8'h10;
		wait_int(1'b0);
		ext1 <= ext1 ^ 8'h01;
		wait_int(1'b1);
		chk_pair(3'h1);
		wait_int(1'b0);
		// With the enable low the synchronisers freeze, so the alert must not move.
		ce <= 1'b0;
		ext1 <= ext1 ^ 8'h02;
		host.q(20);
		chk("ce_hold", int_oe, 1'b0);
		ce <= 1'b1;
		wait_int(1'b1);
		ext1 <= ext1 ^ 8'h02;
		wait_int(1'b0);
		xfer(3'h6, 1, 16'hFE00, 1'b0);
		regs[6] = 8'hFE;
		// Drive bit 0 against its latched input level; an output pin must never alert.
		xfer(3'h2, 1, {regs[2][7:1], ~ext0[0], 8'h00}, 1'b0);
		regs[2][0] = ~ext0[0];
		host.q(20);
		chk("pin_out", out0, regs[2]);
		chk("out_alert", int_oe, 1'b0);
		complete_run();
	end

endmodule
